// *** sim/aos_analog_out_monitor.sv ***
module aos_analog_out_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [15:0] level0_o,
  input wire logic [1:0] range0_o,
  input wire logic [1:0] range1_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // access steps
  // ----------------------------------------
  sequence acc_s;
    psel_i && penable_i;
  endsequence
  sequence wr_type_s(logic [11:0] a, logic [31:0] v);
    acc_s ##0 (pwrite_i && paddr_i == a && pwdata_i == v);
  endsequence
  a_ready_high: assert property (acc_s |-> pready_o) else $error("pready low in access");
  a_rd_idle_zero: assert property (!(psel_i && !pwrite_i) |-> prdata_o == 32'h0) else $error("stray read data");
  a_unmapped_err: assert property (acc_s ##0 (!pwrite_i && paddr_i == 12'h07C) |-> pslverr_o)
    else $error("no error on unmapped read");
  a_type0_volt: assert property (wr_type_s(12'h000, 32'h1) |=> range0_o == 2'h1) else $error("ch0 type not taken");
  a_type1_volt: assert property (wr_type_s(12'h080, 32'h1) |=> range1_o == 2'h1) else $error("ch1 type not taken");
  a_type_bad: assert property (wr_type_s(12'h000, 32'h3) |=> $stable(range0_o)) else $error("bad type taken");
  a_volt_clamp: assert property ((range0_o == 2'h1) [*2] |-> level0_o <= 16'h2710) else $error("volt over range");
  a_cur_clamp: assert property (level0_o <= 16'h4E20) else $error("current over range");
  a_lift_420: assert property ((range0_o == 2'h2) [*3] |-> level0_o >= 16'h0FA0) else $error("below 4 mA");
endmodule // aos_analog_out_monitor
bind aos_analog_out aos_analog_out_monitor mon_i (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .level0_o, .range0_o, .range1_o);

// *** sim/aos_conv_model.sv ***
module aos_conv_model (
  input wire logic clk_i,
  input wire logic [15:0] level_i,
  input wire logic [1:0] range_i,
  output logic [15:0] drive_o,
  output logic volt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // the stage follows the level one edge late, as a sampling converter would
  always_ff @(posedge clk_i) begin
    drive_o <= level_i;
    volt_o <= (range_i == 2'h1);
  end
endmodule // aos_conv_model

// *** sim/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, volt;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic signed [15:0] act = 16'sh0000;
  logic [7:0] ctrl = 8'h00;
  logic [15:0] lv0, lv1, drv;
  logic [1:0] rg0, rg1;
  int n_errors = 0, checks_done = 0;
  logic [31:0] rows [6][4] = '{'{0, 'h15, 8192, 10000}, '{1, 'h18, 8192, 5000}, '{2, 'h19, 8192, 12000},
    '{0, 'h1A, 16384, 20000}, '{1, 'h1B, 'hE000, 0}, '{2, 'h00, 8192, 4000}};
  always #2 clk = ~clk;
  aos_analog_out aos_analog_out_i (.clk_i(clk), .reset_i(reset), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .act_freq_i(act), .act_out_freq_i(act), .act_out_volt_i(act), .act_dc_volt_i(act),
    .act_cur_i(act), .ctrl_sig_i(ctrl), .level0_o(lv0), .level1_o(lv1), .range0_o(rg0), .range1_o(rg1));
  aos_conv_model aos_conv_model_i (.clk_i(clk), .level_i(lv0), .range_i(rg0), .drive_o(drv), .volt_o(volt));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = pslverr ? 32'hDEAD0000 | prdata : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next call never drives psel twice in one step
    @(posedge clk);
  endtask
  task report_and_stop;
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h2710);
    apb(0, 12'h040, 0);
    chk(rd, 32'h0);
    chk(lv0, 16'h0);
    // ----------------------------------------
    // range, reload and signal source table
    // ----------------------------------------
    for (int i = 0; i < 6; i++) begin
      apb(1, 12'h000, rows[i][0]);
      apb(1, 12'h020, rows[i][1]);
      act <= 16'(rows[i][2]);
      apb(0, 12'h008, 0);
      chk(rd, rows[i][0] == 2 ? 32'h0FA0 : 32'h0);
      apb(0, 12'h010, 0);
      chk(rd, rows[i][0] == 1 ? 32'h2710 : 32'h4E20);
      repeat (4) @(posedge clk);
      chk(lv0, rows[i][3]);
      chk(drv, rows[i][3]);
      chk({rg0, volt}, {rows[i][0][1:0], rows[i][0] == 1});
    end
    // ----------------------------------------
    // awkward cases
    // ----------------------------------------
    apb(0, 12'h07C, 0);
    chk(rd, 32'hDEAD0000);
    apb(1, 12'h000, 3);
    apb(0, 12'h000, 0);
    chk(rd, 32'h2);
    apb(1, 12'h080, 1);
    apb(0, 12'h090, 0);
    chk(rd, 32'h2710);
    chk({rg1, rg0}, 4'h6);
    // half the voltage reference makes the same input read as full scale
    apb(1, 12'h054, 'h2000);
    apb(1, 12'h0A0, 'h19);
    repeat (2) @(posedge clk);
    chk(lv1, 16'd10000);
    apb(1, 12'h000, 0);
    apb(1, 12'h020, 'h1B);
    apb(1, 12'h018, 1);
    act <= -16'sd8192;
    repeat (4) @(posedge clk);
    chk(lv0, 16'd10000);
    apb(0, 12'h040, 0);
    chk(rd, 32'h1);
    apb(1, 12'h018, 0);
    apb(1, 12'h01C, 3);
    ctrl <= 8'h08;
    repeat (4) @(posedge clk);
    chk(lv0, 16'd10000);
    ctrl <= 8'h00;
    act <= 16'sd12288;
    apb(1, 12'h00C, 5000);
    repeat (4) @(posedge clk);
    chk(lv0, 16'h4E20);
    apb(1, 12'h014, 4);
    act <= 16'sd0;
    repeat (3) @(posedge clk);
    chk(lv0 != 16'h0, 1'b1);
    report_and_stop;
  end
endmodule // tb_top

// *** src/aos_analog_out.sv ***
`include "aos_params.svh"
module aos_analog_out
  import aos_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic signed [15:0] act_freq_i,
  input wire logic signed [15:0] act_out_freq_i,
  input wire logic signed [15:0] act_out_volt_i,
  input wire logic signed [15:0] act_dc_volt_i,
  input wire logic signed [15:0] act_cur_i,
  input wire logic [7:0] ctrl_sig_i,
  output logic [15:0] level0_o,
  output logic [15:0] level1_o,
  output logic [1:0] range0_o,
  output logic [1:0] range1_o
);
  // inputs are signed; a value equal to the selected reference reads as 100 percent
  // x coordinates: 0.01 percent units; y levels: 0.001 V or 0.001 mA
  aos_cfg_s cfg_q [2];
  logic [15:0] ref_spd_q, ref_vlt_q, ref_cur_q;
  logic [1:0] neg_q;
  logic signed [15:0] lvl_q [2];
  logic signed [31:0] flt_q [2];

  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire apb_rd = psel_i && penable_i && !pwrite_i;
  wire ch_hit = paddr_i[11:8] == 4'h0;
  wire ch = paddr_i[`AOS_CH_STRIDE_BIT];
  wire [11:0] reg_off = {paddr_i[11:8], 1'b0, paddr_i[6:0]};

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic [15:0] y_max(input logic [1:0] t);
    y_max = (t == `AOS_TYPE_V010) ? `AOS_LVL_10V : `AOS_LVL_20MA;
  endfunction
  function automatic logic [15:0] y_min(input logic [1:0] t);
    y_min = (t == `AOS_TYPE_I420) ? `AOS_LVL_4MA : `AOS_LVL_ZERO;
  endfunction
  function automatic logic chan_reg(input logic [11:0] o);
    chan_reg = (o <= `AOS_OFF_SEL) && (o[1:0] == 2'h0);
  endfunction

  //------------------------------------------------------------
  // configuration registers
  //------------------------------------------------------------
  // a write that changes the type also reloads the characteristic
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int c = 0; c < 2; c++) begin
        cfg_q[c].out_type <= `AOS_TYPE_I020;
        cfg_q[c].p1x <= `AOS_LVL_ZERO;
        cfg_q[c].p1y <= `AOS_LVL_ZERO;
        cfg_q[c].p2x <= `AOS_PCT_100;
        cfg_q[c].p2y <= `AOS_LVL_20MA;
        cfg_q[c].smooth_shift <= 5'h00;
        cfg_q[c].abs_en <= 1'b0;
        cfg_q[c].inv_src <= 3'h0;
        cfg_q[c].sig_sel <= `AOS_SEL_LOCK;
      end
    end else if (apb_wr && ch_hit) begin
      unique case (reg_off)
        `AOS_OFF_TYPE: begin
          if (pwdata_i[1:0] <= `AOS_TYPE_I420) begin
            cfg_q[ch].out_type <= pwdata_i[1:0];
            if (pwdata_i[1:0] != cfg_q[ch].out_type) begin
              cfg_q[ch].p1x <= `AOS_LVL_ZERO;
              cfg_q[ch].p1y <= y_min(pwdata_i[1:0]);
              cfg_q[ch].p2x <= `AOS_PCT_100;
              cfg_q[ch].p2y <= y_max(pwdata_i[1:0]);
            end
          end
        end
        `AOS_OFF_P1X: cfg_q[ch].p1x <= pwdata_i[15:0];
        `AOS_OFF_P1Y: cfg_q[ch].p1y <= pwdata_i[15:0];
        `AOS_OFF_P2X: cfg_q[ch].p2x <= pwdata_i[15:0];
        `AOS_OFF_P2Y: cfg_q[ch].p2y <= pwdata_i[15:0];
        `AOS_OFF_SMOOTH: begin
          // a shift beyond the maximum would freeze the filter
          if (pwdata_i[4:0] <= `AOS_SMOOTH_MAX) cfg_q[ch].smooth_shift <= pwdata_i[4:0];
        end
        `AOS_OFF_ABS: cfg_q[ch].abs_en <= pwdata_i[0];
        `AOS_OFF_INV: cfg_q[ch].inv_src <= pwdata_i[2:0];
        `AOS_OFF_SEL: cfg_q[ch].sig_sel <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_spd_q <= `AOS_REF_RESET;
      ref_vlt_q <= `AOS_REF_RESET;
      ref_cur_q <= `AOS_REF_RESET;
    end else if (apb_wr) begin
      if (paddr_i == `AOS_OFF_REFSPD) ref_spd_q <= pwdata_i[15:0];
      if (paddr_i == `AOS_OFF_REFVLT) ref_vlt_q <= pwdata_i[15:0];
      if (paddr_i == `AOS_OFF_REFCUR) ref_cur_q <= pwdata_i[15:0];
    end
  end

  //------------------------------------------------------------
  // per-channel signal chain
  //------------------------------------------------------------
  // channel 1 registers sit 0x80 above channel 0; both chains are alike
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic signed [15:0] src;
    logic [15:0] refv;
    logic signed [47:0] pct_wide;
    logic signed [31:0] pct;
    logic signed [31:0] flt_d;
    logic signed [31:0] sm;
    logic signed [31:0] mag;
    logic signed [31:0] dx;
    logic signed [63:0] num;
    logic signed [63:0] yv;
    logic signed [31:0] yc;
    logic signed [63:0] y_hi;
    logic signed [63:0] y_lo;
    logic inv;

    always_comb begin
      unique case (cfg_q[g].sig_sel)
        `AOS_SEL_FREQ: begin src = act_freq_i; refv = ref_spd_q; end
        `AOS_SEL_OFREQ: begin src = act_out_freq_i; refv = ref_spd_q; end
        `AOS_SEL_OVOLT: begin src = act_out_volt_i; refv = ref_vlt_q; end
        `AOS_SEL_DCV: begin src = act_dc_volt_i; refv = ref_vlt_q; end
        `AOS_SEL_CUR: begin src = act_cur_i; refv = ref_cur_q; end
        default: begin src = 16'sh0000; refv = ref_spd_q; end
      endcase
    end

    // input scaled to percent of its category reference, in 0.01 percent units
    // a zero reference would divide by zero, so the scaled input then reads zero percent
    assign pct_wide = (refv == 16'h0000) ? 48'sh0 :
      (48'(src) * 48'(signed'({16'h0000, `AOS_PCT_100}))) / 48'(signed'({1'b0, refv}));
    assign pct = 32'(pct_wide);

    // shift-based low-pass trades exact time constants for no divider
    assign flt_d = flt_q[g] + ((pct - flt_q[g]) >>> cfg_q[g].smooth_shift);
    always_ff @(posedge clk_i) begin
      if (reset_i) flt_q[g] <= 32'sh0;
      else flt_q[g] <= flt_d;
    end
    assign sm = flt_q[g];

    assign inv = ctrl_sig_i[cfg_q[g].inv_src];
    always_comb begin
      mag = (cfg_q[g].abs_en && sm < 0) ? -sm : sm;
      if (inv) mag = -mag;
      dx = 32'(cfg_q[g].p2x) - 32'(cfg_q[g].p1x);
      num = 64'(mag - 32'(cfg_q[g].p1x)) * 64'(32'(cfg_q[g].p2y) - 32'(cfg_q[g].p1y));
      // degenerate line with equal x values holds point one's level
      yv = (dx == 32'sh0) ? 64'(cfg_q[g].p1y) : 64'(cfg_q[g].p1y) + num / 64'(dx);
      // limits widened as signed values, so a negative line value clamps low
      y_hi = 64'(signed'({1'b0, y_max(cfg_q[g].out_type)}));
      y_lo = 64'(signed'({1'b0, y_min(cfg_q[g].out_type)}));
      if (yv > y_hi) yc = 32'(y_hi);
      else if (yv < y_lo) yc = 32'(y_lo);
      else yc = 32'(yv);
      if (cfg_q[g].sig_sel == `AOS_SEL_LOCK) yc = 32'(y_lo);
    end

    // status is live: it follows the filtered sign and does not latch
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        lvl_q[g] <= 16'sh0000;
        neg_q[g] <= 1'b0;
      end else begin
        lvl_q[g] <= yc[15:0];
        neg_q[g] <= cfg_q[g].abs_en && (sm < 0);
      end
    end
  end

  assign level0_o = lvl_q[0];
  assign level1_o = lvl_q[1];
  assign range0_o = cfg_q[0].out_type;
  assign range1_o = cfg_q[1].out_type;

  //------------------------------------------------------------
  // read path
  //------------------------------------------------------------
  // every register answers in its first access cycle, so no wait states
  assign pready_o = 1'b1;
  always_comb begin
    prdata_o = 32'h0;
    pslverr_o = 1'b0;
    if (apb_rd && ch_hit && chan_reg(reg_off)) begin
      unique case (reg_off)
        `AOS_OFF_TYPE: prdata_o = {30'h0, cfg_q[ch].out_type};
        `AOS_OFF_P1X: prdata_o = {16'h0, cfg_q[ch].p1x};
        `AOS_OFF_P1Y: prdata_o = {16'h0, cfg_q[ch].p1y};
        `AOS_OFF_P2X: prdata_o = {16'h0, cfg_q[ch].p2x};
        `AOS_OFF_P2Y: prdata_o = {16'h0, cfg_q[ch].p2y};
        `AOS_OFF_SMOOTH: prdata_o = {27'h0, cfg_q[ch].smooth_shift};
        `AOS_OFF_ABS: prdata_o = {31'h0, cfg_q[ch].abs_en};
        `AOS_OFF_INV: prdata_o = {29'h0, cfg_q[ch].inv_src};
        `AOS_OFF_SEL: prdata_o = {24'h0, cfg_q[ch].sig_sel};
        default: prdata_o = 32'h0;
      endcase
    end else if (apb_rd) begin
      unique case (paddr_i)
        `AOS_OFF_STATUS: prdata_o = {30'h0, neg_q};
        `AOS_OFF_LEVEL0: prdata_o = {16'h0, lvl_q[0]};
        `AOS_OFF_LEVEL1: prdata_o = {16'h0, lvl_q[1]};
        `AOS_OFF_REFSPD: prdata_o = {16'h0, ref_spd_q};
        `AOS_OFF_REFVLT: prdata_o = {16'h0, ref_vlt_q};
        `AOS_OFF_REFCUR: prdata_o = {16'h0, ref_cur_q};
        default: pslverr_o = 1'b1;
      endcase
    end
  end
endmodule // aos_analog_out

// *** src/aos_params.svh ***
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - type 0 is 0-20mA, 1 is 0-10V, 2 is 4-20mA
// - index 0 is first channel, 1 second
// - type change reloads four scaling defaults
// - two points define the characteristic
// - x in percent, y in volts or milliamps
// - first-order smoothing, time constant per channel
// - absolute value enable passes or takes magnitude
// - negative input with magnitude sets status bit
// - selected control source negates the input signal
// - signal select zero locks the output
// - reference chosen by signal category
`ifndef AOS_PARAMS_SVH
`define AOS_PARAMS_SVH
`define AOS_OFF_TYPE 12'h000
`define AOS_OFF_P1X 12'h004
`define AOS_OFF_P1Y 12'h008
`define AOS_OFF_P2X 12'h00C
`define AOS_OFF_P2Y 12'h010
`define AOS_OFF_SMOOTH 12'h014
`define AOS_OFF_ABS 12'h018
`define AOS_OFF_INV 12'h01C
`define AOS_OFF_SEL 12'h020
`define AOS_OFF_STATUS 12'h040
`define AOS_OFF_LEVEL0 12'h044
`define AOS_OFF_LEVEL1 12'h048
`define AOS_OFF_REFSPD 12'h050
`define AOS_OFF_REFVLT 12'h054
`define AOS_OFF_REFCUR 12'h058
`define AOS_CH_STRIDE_BIT 7
`define AOS_TYPE_I020 2'h0
`define AOS_TYPE_V010 2'h1
`define AOS_TYPE_I420 2'h2
`define AOS_SEL_LOCK 8'h00
`define AOS_SEL_FREQ 8'h15
`define AOS_SEL_OFREQ 8'h18
`define AOS_SEL_OVOLT 8'h19
`define AOS_SEL_DCV 8'h1A
`define AOS_SEL_CUR 8'h1B
`define AOS_PCT_100 16'h2710
`define AOS_LVL_20MA 16'h4E20
`define AOS_LVL_10V 16'h2710
`define AOS_LVL_4MA 16'h0FA0
`define AOS_LVL_ZERO 16'h0000
`define AOS_REF_RESET 16'h4000
`define AOS_SMOOTH_MAX 5'h10
`endif

// *** src/aos_pkg.sv ***
package aos_pkg;
  typedef enum logic [1:0] {
    AOS_T_I020,
    AOS_T_V010,
    AOS_T_I420
  } aos_type_e;
  typedef struct packed {
    logic [1:0] out_type;
    logic signed [15:0] p1x;
    logic signed [15:0] p1y;
    logic signed [15:0] p2x;
    logic signed [15:0] p2y;
    logic [4:0] smooth_shift;
    logic abs_en;
    logic [2:0] inv_src;
    logic [7:0] sig_sel;
  } aos_cfg_s;
endpackage
